/* File: hdl/apc_pkg.sv */
/*
 * Shared constants for the audio channel power control block: register
 * offsets, field positions, reset values, scope masks and channel settle time.
 * Assumes an 8-bit control port address and an 8-bit data path.
 */
package apc_pkg;

    // ------------------------------------------------------------------
    // register offsets on the control port
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_DYN_POWER_CFG = 8'h77;
    localparam logic [7:0] ADDR_POWER_CFG     = 8'h78;
    localparam logic [7:0] ADDR_POWER_STATUS  = 8'h79;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_DYN_POWER_CFG  = 8'h00;
    localparam logic [7:0] RST_POWER_CFG      = 8'h00;
    localparam logic [7:0] RST_READ_DATA      = 8'h00;

    // ------------------------------------------------------------------
    // dynamic power configuration fields
    // ------------------------------------------------------------------
    localparam int         BIT_REC_DYN_EN     = 7;
    localparam int         BIT_REC_DYN_SCOPE  = 6;
    localparam int         BIT_PB_DYN_EN      = 5;
    localparam int         BIT_PB_DYN_SCOPE   = 4;
    localparam int         BIT_SPLIT_CLOCK    = 3;
    localparam logic [7:0] MASK_DYN_POWER_CFG = 8'hf8;

    // ------------------------------------------------------------------
    // power configuration fields
    // ------------------------------------------------------------------
    localparam int         BIT_REC_POWER_ON   = 7;
    localparam int         BIT_PB_POWER_ON    = 6;
    localparam int         BIT_MIC_BIAS_ON    = 5;
    localparam int         BIT_US_DETECT_EN   = 3;
    localparam int         BIT_VOICE_DET_EN   = 2;
    localparam int         BIT_US_AUX_EN      = 1;
    localparam logic [7:0] MASK_POWER_CFG     = 8'hee;

    // ------------------------------------------------------------------
    // dynamic switching scope (index 0 is channel one)
    // ------------------------------------------------------------------
    localparam logic [3:0] SCOPE_NARROW       = 4'h3;
    localparam logic [3:0] SCOPE_WIDE         = 4'hf;
    localparam logic [3:0] CHAN_NONE          = 4'h0;

    // ------------------------------------------------------------------
    // timing: channel power transition settle time
    // ------------------------------------------------------------------
    localparam int         CLK_PERIOD_NS      = 10;
    localparam int         SETTLE_NS          = 1000;
    localparam int         SETTLE_CYC         = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : apc_pkg

/* File: hdl/apc_chan_ramp.sv */
/*
 * One channel's power transition model: the powered flag follows the
 * command only after the command has held steady for the settle time.
 * Assumes the command comes from logic on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none

module apc_chan_ramp #(
    parameter int SETTLE = apc_pkg::SETTLE_CYC
) (
    input  wire logic clock_i,
    input  wire logic rst_i,
    input  wire logic cmd_i,
    output logic      powered_o
);

    localparam int         CW   = $clog2(SETTLE + 1);
    localparam logic [CW-1:0] LAST = CW'(SETTLE - 1);

    logic          powered_ff;
    logic [CW-1:0] cnt_ff;

    // ------------------------------------------------------------------
    // settle counter, restarts whenever the command agrees again
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_ff <= '0;
        end else if (cmd_i == powered_ff || cnt_ff == LAST) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + CW'(1);
        end
    end

    // status flips only once the transition has completed
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            powered_ff <= 1'b0;
        end else if (cmd_i != powered_ff && cnt_ff == LAST) begin
            powered_ff <= cmd_i;
        end
    end

    assign powered_o = powered_ff;

    chk_ramp_hold:
    assert property (@(posedge clock_i) disable iff (rst_i)
        (cmd_i != powered_ff && cnt_ff != LAST) |=> $stable(powered_ff))
    else $error("channel status moved before settle time");

    chk_ramp_done:
    assert property (@(posedge clock_i) disable iff (rst_i)
        (cmd_i != powered_ff && cnt_ff == LAST) |=> powered_ff == $past(cmd_i))
    else $error("channel status missed end of transition");

endmodule : apc_chan_ramp

`default_nettype wire

/* File: hdl/apc_path_ctrl.sv */
/*
 * Channel command logic for one path (record or playback): applies the
 * path power bit, the channel enables, and the dynamic switching policy.
 * Assumes all inputs come from logic on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none

module apc_path_ctrl (
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic       power_on_i,
    input  wire logic       dyn_en_i,
    input  wire logic       scope_i,
    input  wire logic [3:0] enable_i,
    input  wire logic [3:0] powered_i,
    output logic      [3:0] cmd_o
);

    logic [3:0] cmd_ff;
    logic [3:0] nxt_cmd;
    logic [3:0] scope_mask;
    logic       busy;

    assign scope_mask = scope_i ? apc_pkg::SCOPE_WIDE : apc_pkg::SCOPE_NARROW;
    // path counts as active while any channel is on or still ramping
    assign busy       = (cmd_ff | powered_i) != apc_pkg::CHAN_NONE;

    // ------------------------------------------------------------------
    // next command: off wins, idle path takes the enables as they stand
    // ------------------------------------------------------------------
    always_comb begin
        if (!power_on_i) begin
            nxt_cmd = apc_pkg::CHAN_NONE;
        end else if (!busy) begin
            nxt_cmd = enable_i;
        end else if (dyn_en_i) begin
            // channels outside the scope keep their state
            nxt_cmd = (enable_i & scope_mask) | (cmd_ff & ~scope_mask);
        end else begin
            nxt_cmd = cmd_ff;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cmd_ff <= apc_pkg::CHAN_NONE;
        end else begin
            cmd_ff <= nxt_cmd;
        end
    end

    assign cmd_o = cmd_ff;

    chk_static_hold:
    assert property (@(posedge clock_i) disable iff (rst_i)
        (power_on_i && busy && !dyn_en_i) |=> $stable(cmd_ff))
    else $error("channel set changed while path active without dynamic mode");

    chk_scope_hold:
    assert property (@(posedge clock_i) disable iff (rst_i)
        (power_on_i && busy && dyn_en_i && !scope_i) |=> cmd_ff[3:2] == $past(cmd_ff[3:2]))
    else $error("channel outside narrow scope switched dynamically");

    chk_path_off:
    assert property (@(posedge clock_i) disable iff (rst_i)
        !power_on_i |=> cmd_ff == apc_pkg::CHAN_NONE)
    else $error("path power off left a channel commanded on");

    chk_enabled_only:
    assert property (@(posedge clock_i) disable iff (rst_i)
        (power_on_i && !busy) |=> cmd_ff == $past(enable_i))
    else $error("idle power-up did not follow channel enables");

endmodule : apc_path_ctrl

`default_nettype wire

/* File: hdl/apc_power_ctrl.sv */
/*
 * Audio channel power control: dynamic power configuration, power
 * configuration and channel power status registers on the control port,
 * record and playback channel sequencing, mic bias and detection enables.
 * Assumes the control port and the channel enable byte are driven by logic
 * on clock_i; the channel enable byte is owned by a neighbouring register.
 */
// Overview of operation
// - record dynamic enable lets channels switch while recording; else changes held
// - record scope bit: 0 limits dynamic switching to channels 1-2, 1 to 1-4
// - playback dynamic enable lets channels switch during playback; else changes held
// - playback scope bit: 0 covers channels 1-2, 1 covers channels 1-4
// - split clock bit tells dynamic switching whether modulator and mic clocks differ
// - dynamic config bits 2..0 read zero; software writes zero there
// - record power bit off powers down all record channels, on powers enabled ones
// - playback power bit off powers down all playback channels, on powers enabled ones
// - mic bias power bit switches the mic bias supply
// - power config bit 3 enables ultrasound activity detection
// - power config bit 2 enables voice activity detection
// - power config bit 1 enables auxiliary ultrasound algorithm; bits 4, 0 read zero
// - status bits 7..4 report record channels one to four powered
// - status bits 3..0 report playback channels one to four powered
// - power configuration resets to zero, everything off or disabled
// - power-up applies only to channels set in the channel enable byte
`timescale 1ns/1ns
`default_nettype none

module apc_power_ctrl #(
    parameter int SETTLE = apc_pkg::SETTLE_CYC
) (
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    // control port
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    // channel enable byte: record ch1..4 in bits 7..4, playback ch1..4 in 3..0
    input  wire logic [7:0] channel_enable_i,
    // channel power commands, index 0 is channel one
    output logic      [3:0] record_power_o,
    output logic      [3:0] playback_power_o,
    output logic            mic_bias_power_on_o,
    output logic            ultrasound_detect_enable_o,
    output logic            voice_detect_enable_o,
    output logic            ultrasound_aux_enable_o,
    output logic            dynamic_split_clock_select_o
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // register bytes put channel one in the top bit of each nibble
    function automatic logic [3:0] apc_flip4(input logic [3:0] v);
        apc_flip4 = {v[0], v[1], v[2], v[3]};
    endfunction : apc_flip4

    function automatic logic apc_hit(input logic [7:0] addr, input logic [7:0] reg_addr);
        apc_hit = (addr == reg_addr);
    endfunction : apc_hit

    // ------------------------------------------------------------------
    // registers and internal signals
    // ------------------------------------------------------------------
    logic [7:0] dyn_cfg_ff;
    logic [7:0] power_config_ff;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic [3:0] rec_cmd;
    logic [3:0] pb_cmd;
    logic [3:0] rec_powered;
    logic [3:0] pb_powered;
    logic [7:0] status_byte;
    logic       mic_bias_ff;
    logic       us_det_ff;
    logic       voice_det_ff;
    logic       us_aux_ff;
    logic       split_clk_ff;

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    // reserved bits are masked on write so they always read back zero
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            dyn_cfg_ff <= apc_pkg::RST_DYN_POWER_CFG;
        end else if (reg_wr_i && apc_hit(reg_addr_i, apc_pkg::ADDR_DYN_POWER_CFG)) begin
            dyn_cfg_ff <= reg_wdata_i & apc_pkg::MASK_DYN_POWER_CFG;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            power_config_ff <= apc_pkg::RST_POWER_CFG;
        end else if (reg_wr_i && apc_hit(reg_addr_i, apc_pkg::ADDR_POWER_CFG)) begin
            power_config_ff <= reg_wdata_i & apc_pkg::MASK_POWER_CFG;
        end
    end
    // the status offset has no write decode at all, so a write there is dropped

    // ------------------------------------------------------------------
    // status byte, channel one in the high bit of each nibble
    // ------------------------------------------------------------------
    assign status_byte = {apc_flip4(rec_powered), apc_flip4(pb_powered)};

    // ------------------------------------------------------------------
    // read data, answered the cycle after the read strobe
    // ------------------------------------------------------------------
    always_comb begin
        case (reg_addr_i)
            apc_pkg::ADDR_DYN_POWER_CFG: nxt_rdata = dyn_cfg_ff;
            apc_pkg::ADDR_POWER_CFG:     nxt_rdata = power_config_ff;
            apc_pkg::ADDR_POWER_STATUS:  nxt_rdata = status_byte;
            default:                     nxt_rdata = apc_pkg::RST_READ_DATA;
        endcase
    end

    // data holds until the next read so a slow port can sample it late
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_ff <= apc_pkg::RST_READ_DATA;
        end else if (reg_rd_i) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata_o = rdata_ff;

    // ------------------------------------------------------------------
    // record and playback path command logic
    // ------------------------------------------------------------------
    apc_path_ctrl u_record_path (
        .clock_i    (clock_i),
        .rst_i      (rst_i),
        .power_on_i (power_config_ff[apc_pkg::BIT_REC_POWER_ON]),
        .dyn_en_i   (dyn_cfg_ff[apc_pkg::BIT_REC_DYN_EN]),
        .scope_i    (dyn_cfg_ff[apc_pkg::BIT_REC_DYN_SCOPE]),
        .enable_i   (apc_flip4(channel_enable_i[7:4])),
        .powered_i  (rec_powered),
        .cmd_o      (rec_cmd)
    );

    apc_path_ctrl u_playback_path (
        .clock_i    (clock_i),
        .rst_i      (rst_i),
        .power_on_i (power_config_ff[apc_pkg::BIT_PB_POWER_ON]),
        .dyn_en_i   (dyn_cfg_ff[apc_pkg::BIT_PB_DYN_EN]),
        .scope_i    (dyn_cfg_ff[apc_pkg::BIT_PB_DYN_SCOPE]),
        .enable_i   (apc_flip4(channel_enable_i[3:0])),
        .powered_i  (pb_powered),
        .cmd_o      (pb_cmd)
    );

    assign record_power_o   = rec_cmd;
    assign playback_power_o = pb_cmd;

    // ------------------------------------------------------------------
    // per-channel transitions feeding the status byte
    // ------------------------------------------------------------------
    for (genvar ch = 0; ch < 4; ch++) begin : g_chan
        apc_chan_ramp #(.SETTLE(SETTLE)) u_rec_ramp (
            .clock_i   (clock_i),
            .rst_i     (rst_i),
            .cmd_i     (rec_cmd[ch]),
            .powered_o (rec_powered[ch])
        );
        apc_chan_ramp #(.SETTLE(SETTLE)) u_pb_ramp (
            .clock_i   (clock_i),
            .rst_i     (rst_i),
            .cmd_i     (pb_cmd[ch]),
            .powered_o (pb_powered[ch])
        );
    end

    // ------------------------------------------------------------------
    // mic bias, detection enables and clocking select
    // ------------------------------------------------------------------
    // separate flops keep these outputs glitch free and off the decode path
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            mic_bias_ff  <= 1'b0;
            us_det_ff    <= 1'b0;
            voice_det_ff <= 1'b0;
            us_aux_ff    <= 1'b0;
            split_clk_ff <= 1'b0;
        end else begin
            mic_bias_ff  <= power_config_ff[apc_pkg::BIT_MIC_BIAS_ON];
            us_det_ff    <= power_config_ff[apc_pkg::BIT_US_DETECT_EN];
            voice_det_ff <= power_config_ff[apc_pkg::BIT_VOICE_DET_EN];
            us_aux_ff    <= power_config_ff[apc_pkg::BIT_US_AUX_EN];
            split_clk_ff <= dyn_cfg_ff[apc_pkg::BIT_SPLIT_CLOCK];
        end
    end

    assign mic_bias_power_on_o          = mic_bias_ff;
    assign ultrasound_detect_enable_o   = us_det_ff;
    assign voice_detect_enable_o        = voice_det_ff;
    assign ultrasound_aux_enable_o      = us_aux_ff;
    assign dynamic_split_clock_select_o = split_clk_ff;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    chk_status_ignored:
    assert property (@(posedge clock_i) disable iff (rst_i)
        (reg_wr_i && reg_addr_i == apc_pkg::ADDR_POWER_STATUS)
        |=> $stable(dyn_cfg_ff) && $stable(power_config_ff))
    else $error("status write disturbed configuration");

    chk_dyn_reserved:
    assert property (@(posedge clock_i) disable iff (rst_i)
        (reg_wr_i && reg_addr_i == apc_pkg::ADDR_DYN_POWER_CFG)
        |=> dyn_cfg_ff[2:0] == 3'h0 && dyn_cfg_ff[7:3] == $past(reg_wdata_i[7:3]))
    else $error("dynamic config write stored wrong bits");

    chk_pwr_reserved:
    assert property (@(posedge clock_i) disable iff (rst_i)
        (reg_wr_i && reg_addr_i == apc_pkg::ADDR_POWER_CFG)
        |=> power_config_ff[4] == 1'b0 && power_config_ff[0] == 1'b0 && power_config_ff[1] == $past(reg_wdata_i[1]))
    else $error("power config write stored wrong bits");

    chk_bias_follow:
    assert property (@(posedge clock_i) disable iff (rst_i)
        (reg_wr_i && reg_addr_i == apc_pkg::ADDR_POWER_CFG)
        |=> ##1 mic_bias_power_on_o == $past(reg_wdata_i[5], 2))
    else $error("mic bias did not follow written bit");

    chk_voice_follow:
    assert property (@(posedge clock_i) disable iff (rst_i)
        (reg_wr_i && reg_addr_i == apc_pkg::ADDR_POWER_CFG)
        |=> ##1 voice_detect_enable_o == $past(reg_wdata_i[2], 2))
    else $error("voice detect enable did not follow written bit");

    chk_status_read:
    assert property (@(posedge clock_i) disable iff (rst_i)
        (reg_rd_i && reg_addr_i == apc_pkg::ADDR_POWER_STATUS)
        |=> reg_rdata_o == {$past(rec_powered[0]), $past(rec_powered[1]),
                            $past(rec_powered[2]), $past(rec_powered[3]),
                            $past(pb_powered[0]), $past(pb_powered[1]),
                            $past(pb_powered[2]), $past(pb_powered[3])})
    else $error("status read returned wrong channel order");

    chk_unmapped_zero:
    assert property (@(posedge clock_i) disable iff (rst_i)
        (reg_rd_i && reg_addr_i != apc_pkg::ADDR_DYN_POWER_CFG
         && reg_addr_i != apc_pkg::ADDR_POWER_CFG
         && reg_addr_i != apc_pkg::ADDR_POWER_STATUS) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read returned nonzero");

    chk_playback_off:
    assert property (@(posedge clock_i) disable iff (rst_i)
        !power_config_ff[apc_pkg::BIT_PB_POWER_ON] |=> playback_power_o == 4'h0)
    else $error("playback power off left a channel on");

    // ------------------------------------------------------------------
    // configuration outputs, record power off, read-back of reserved bits, read data kept on status write
    // ------------------------------------------------------------------
    chk_detect_follow:
    assert property (@(posedge clock_i) disable iff (rst_i)
        (reg_wr_i && reg_addr_i == apc_pkg::ADDR_POWER_CFG)
        |=> ##1 ultrasound_detect_enable_o == $past(reg_wdata_i[3], 2))
    else $error("ultrasound detect enable did not follow written bit");

    chk_aux_follow:
    assert property (@(posedge clock_i) disable iff (rst_i)
        (reg_wr_i && reg_addr_i == apc_pkg::ADDR_POWER_CFG)
        |=> ##1 ultrasound_aux_enable_o == $past(reg_wdata_i[1], 2))
    else $error("aux ultrasound enable did not follow written bit");

    chk_split_follow:
    assert property (@(posedge clock_i) disable iff (rst_i)
        (reg_wr_i && reg_addr_i == apc_pkg::ADDR_DYN_POWER_CFG)
        |=> ##1 dynamic_split_clock_select_o == $past(reg_wdata_i[3], 2))
    else $error("split clock select did not follow written bit");

    chk_record_off:
    assert property (@(posedge clock_i) disable iff (rst_i)
        !power_config_ff[apc_pkg::BIT_REC_POWER_ON]
        |=> record_power_o == 4'h0)
    else $error("record power off left a channel on");

    chk_dyn_read_zero:
    assert property (@(posedge clock_i) disable iff (rst_i)
        (reg_rd_i && reg_addr_i == apc_pkg::ADDR_DYN_POWER_CFG)
        |=> reg_rdata_o[2:0] == 3'h0)
    else $error("dynamic config reserved bits read nonzero");

    chk_pwr_read_zero:
    assert property (@(posedge clock_i) disable iff (rst_i)
        (reg_rd_i && reg_addr_i == apc_pkg::ADDR_POWER_CFG)
        |=> reg_rdata_o[4] == 1'b0 && reg_rdata_o[0] == 1'b0)
    else $error("power config reserved bits read nonzero");

    chk_status_no_load:
    assert property (@(posedge clock_i) disable iff (rst_i)
        (reg_wr_i && reg_addr_i == apc_pkg::ADDR_POWER_STATUS && !reg_rd_i)
        |=> $stable(reg_rdata_o))
    else $error("status write disturbed read data");

endmodule : apc_power_ctrl

`default_nettype wire

/* File: tb/test_audio_channel_power_control.sv */
/*
 * Self-checking bench for the audio channel power control block: register
 * reset values, reserved bits, read-only status, path power sequencing and
 * dynamic switching scopes.
 * Assumes the design files under hdl/ are compiled first; SETTLE is cut to 4.
 */
`timescale 1ns/1ns
`default_nettype none

module test_audio_channel_power_control;

    // ------------------------------------------------------------------
    // signals and counters
    // ------------------------------------------------------------------
    localparam int SETTLE = 4;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic       wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic       rd = 1'b0;
    logic [7:0] ch_en = 8'h00;
    logic [7:0] rdata;
    logic [3:0] rec_pwr, pb_pwr;
    logic       bias, us_det, voice_det, us_aux, split_clk;
    int         err_count = 0;
    int         total_checks = 0;
    int         seed = 33826;
    int         cycles = 0;
    logic [7:0] dyn, e0, e1, er, ep;
    logic [7:0] corner [4] = '{8'h00, 8'ha0, 8'hf0, 8'h80};
    int         bitpos [4] = '{5, 3, 2, 1};

    apc_power_ctrl #(.SETTLE(SETTLE)) i_dut (
        .clock_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .channel_enable_i(ch_en), .record_power_o(rec_pwr), .playback_power_o(pb_pwr),
        .mic_bias_power_on_o(bias), .ultrasound_detect_enable_o(us_det),
        .voice_detect_enable_o(voice_det), .ultrasound_aux_enable_o(us_aux),
        .dynamic_split_clock_select_o(split_clk));

    // free-running clock and a watchdog so a hang still reaches the verdict
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles > 50000) begin
            err_count++;
            summarize();
        end
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // channel one sits in the top bit of the enable nibble but index 0 of commands
    function automatic logic [3:0] rev4(input logic [3:0] n);
        return {n[0], n[1], n[2], n[3]};
    endfunction : rev4

    // expected commands of a busy path after its enables change
    function automatic logic [3:0] nxt_cmd(input logic [3:0] old_c, input logic [3:0] en_c,
                                           input logic dyn_on, input logic wide);
        logic [3:0] m;
        m = wide ? 4'hf : 4'h3;
        if (!dyn_on) return old_c;
        return (en_c & m) | (old_c & ~m);
    endfunction : nxt_cmd

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr = 1'b1; addr = a; wdata = d;
        @(negedge clk);
        wr = 1'b0;
    endtask : wr_reg

    // read data lands on the edge after the strobe, so compare at the next fall
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        rd = 1'b1; addr = a;
        @(negedge clk);
        rd = 1'b0;
        check("read data", rdata, exp);
    endtask : rd_chk

    task automatic settle();
        repeat (3 * SETTLE + 4) @(negedge clk);
    endtask : settle

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        // reset state of registers and outputs
        rd_chk(apc_pkg::ADDR_DYN_POWER_CFG, 8'h00);
        rd_chk(apc_pkg::ADDR_POWER_CFG, 8'h00);
        rd_chk(apc_pkg::ADDR_POWER_STATUS, 8'h00);
        check("path commands", {rec_pwr, pb_pwr}, 8'h00);
        check("misc outputs", {3'h0, bias, us_det, voice_det, us_aux, split_clk}, 8'h00);
        $display("test reset done");

        // reserved bits stay zero, unmapped place ignored
        wr_reg(apc_pkg::ADDR_DYN_POWER_CFG, 8'hff);
        rd_chk(apc_pkg::ADDR_DYN_POWER_CFG, 8'hf8);
        repeat (2) @(negedge clk);
        check("split clock", {7'h0, split_clk}, 8'h01);
        wr_reg(8'h7a, 8'hff);
        rd_chk(8'h7a, 8'h00);
        rd_chk(apc_pkg::ADDR_DYN_POWER_CFG, 8'hf8);
        wr_reg(apc_pkg::ADDR_DYN_POWER_CFG, 8'h00);
        repeat (2) @(negedge clk);
        check("split clock", {7'h0, split_clk}, 8'h00);
        wr_reg(apc_pkg::ADDR_POWER_CFG, 8'h3f);
        rd_chk(apc_pkg::ADDR_POWER_CFG, 8'h2e);
        // one enable bit at a time so a swapped output shows up
        for (int k = 0; k < 4; k++) begin
            wr_reg(apc_pkg::ADDR_POWER_CFG, 8'h01 << bitpos[k]);
            repeat (2) @(negedge clk);
            check("bias and detect", {4'h0, bias, us_det, voice_det, us_aux},
                  8'h08 >> k);
        end
        wr_reg(apc_pkg::ADDR_POWER_CFG, 8'h00);
        $display("test config bits done");

        // path sequencing, corners first, then random dynamic settings
        for (int i = 0; i < 10; i++) begin
            dyn = (i < 4) ? corner[i] : (8'($random(seed)) & 8'hf0);
            e0 = 8'($random(seed)) | 8'h88; // channel one kept on so the path stays busy
            e1 = 8'($random(seed)) | 8'h88;
            ch_en = e0;
            wr_reg(apc_pkg::ADDR_DYN_POWER_CFG, dyn);
            wr_reg(apc_pkg::ADDR_POWER_CFG, 8'hc0);
            rd_chk(apc_pkg::ADDR_POWER_STATUS, 8'h00);
            settle();
            check("record cmd", {4'h0, rec_pwr}, {4'h0, rev4(e0[7:4])});
            check("playback cmd", {4'h0, pb_pwr}, {4'h0, rev4(e0[3:0])});
            rd_chk(apc_pkg::ADDR_POWER_STATUS, e0);
            ch_en = e1;
            settle();
            er = {4'h0, nxt_cmd(rev4(e0[7:4]), rev4(e1[7:4]), dyn[7], dyn[6])};
            ep = {4'h0, nxt_cmd(rev4(e0[3:0]), rev4(e1[3:0]), dyn[5], dyn[4])};
            check("record dyn cmd", {4'h0, rec_pwr}, er);
            check("playback dyn cmd", {4'h0, pb_pwr}, ep);
            wr_reg(apc_pkg::ADDR_POWER_STATUS, 8'h00);
            rd_chk(apc_pkg::ADDR_POWER_STATUS, {rev4(er[3:0]), rev4(ep[3:0])});
            wr_reg(apc_pkg::ADDR_POWER_CFG, 8'h00);
            settle();
            check("path off", {rec_pwr, pb_pwr}, 8'h00);
            rd_chk(apc_pkg::ADDR_POWER_STATUS, 8'h00);
            $display("test sequencing pass %0d done", i);
        end
        summarize();
    end

endmodule : test_audio_channel_power_control

`default_nettype wire
